// ### bench/gpio_function_mapper_asserts.sv
// checker: port relations of the pin function mapper
// assumes: bound to the mapper; setup word steady around pin edges
`timescale 1ns/1ps
module gpio_function_mapper_asserts (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [15:0] pin_setup_word,
   input wire gpio_map_pkg::pin_status_s status,
   input wire gpio_map_pkg::sw_trig_s sw_trig,
   input wire logic wr_req_unlock,
   input wire logic wr_req_reset_i2c,
   input wire logic pin_in,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire gpio_map_pkg::pin_trig_s trig,
   input wire gpio_map_pkg::sw_trig_s sw_trig_eff,
   input wire logic nvm_prog_allow,
   input wire logic reg_write_allow,
   input wire logic reg_write_exempt
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire logic en = pin_setup_word[0];
   wire logic [3:0] ic = pin_setup_word[4:1];
   wire logic [3:0] oc = pin_setup_word[12:9];
   wire logic ok = oc == 4'h1 || oc[3:2] == 2'b01 || oc[3:2] == 2'b10;
   property p_oe; pin_oe |-> $past(pin_setup_word[13] && !en && ok); endproperty
   a_oe: assert property (p_oe) else $error("pin driven");
   property p_busy;
      pin_oe && $past(oc) == 4'h1 |-> pin_out == $past(status.nonvolatile_busy_flag);
   endproperty
   a_busy: assert property (p_busy) else $error("busy not shown");
   property p_marg;
      |{trig.margin_low, trig.margin_high} |-> $past(en && ic == 4'ha) &&
         (trig.margin_low | trig.margin_high) == $past(pin_setup_word[8:5]);
   endproperty
   a_marg: assert property (p_marg) else $error("bad margin");
   property p_rst;
      trig.dev_reset |-> $past(en && ic == 4'hb && pin_in) ##1 !trig.dev_reset;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset");
   property p_mask;
      $past(en && ic == 4'ha) |-> sw_trig_eff[9:2] == 8'h00;
   endproperty
   a_mask: assert property (p_mask) else $error("sw not masked");
   property p_exempt;
      reg_write_exempt == $past(wr_req_unlock || wr_req_reset_i2c);
   endproperty
   a_exempt: assert property (p_exempt) else $error("exempt");
   property p_prog;
      $fell(nvm_prog_allow) |-> $past(en && ic == 4'hc && pin_in);
   endproperty
   a_prog: assert property (p_prog) else $error("prog block");
   property p_lock;
      $fell(reg_write_allow) |-> $past(en && ic == 4'hd && pin_in);
   endproperty
   a_lock: assert property (p_lock) else $error("write block");
endmodule

// ### bench/gpio_function_mapper_test.sv
// testbench: pin mapper against an integer model of the pin functions
// assumes: package, design, checker and partner compiled first
`timescale 1ns/1ps
module gpio_function_mapper_test;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [15:0] word = 16'h00b5;
   gpio_map_pkg::pin_status_s status = '0;
   gpio_map_pkg::sw_trig_s sw = '0;
   logic unl = 1'b0;
   logic ri2c = 1'b0;
   logic pin_in, pin_out, pin_oe, allow, wallow, exempt;
   gpio_map_pkg::pin_trig_s trig, acc;
   gpio_map_pkg::sw_trig_s sw_eff;
   int err_count = 0;
   int comparisons = 0;
   int seed = 5;
   always #10 clk = ~clk;
   gpio_function_mapper u_gpio_function_mapper (.clk(clk), .nrst(nrst),
      .pin_setup_word(word), .status(status), .sw_trig(sw),
      .wr_req_unlock(unl), .wr_req_reset_i2c(ri2c), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .trig(trig), .sw_trig_eff(sw_eff),
      .nvm_prog_allow(allow), .reg_write_allow(wallow),
      .reg_write_exempt(exempt));
   pin_partner u_pin_partner (.clk(clk), .pin_in(pin_in));
   task automatic chk(input string n, input logic [9:0] ex, logic [9:0] got);
      comparisons++;
      if (ex !== got) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, ex, got);
      end
   endtask
   // new pin level, then gather trigger pulses
   task automatic go(input logic v, input int hold);
      acc = '0;
      u_pin_partner.drive(v, 0);
      repeat (hold) begin
         @(negedge clk);
         acc = acc | trig;
      end
   endtask
   function automatic logic [9:0] mdl(input logic [15:0] w, input logic v);
      int sel = w[8:5];
      if (!w[0] || w[4:1] != 4'ha) return 10'h000;
      return v ? 10'(sel << 1) : 10'(sel << 5);
   endfunction
   function automatic logic [9:0] omdl(input logic [15:0] w, logic [8:0] s);
      int c = w[12:9];
      if (!w[13] || w[0]) return 10'h000;
      if (c == 1) return {8'h00, 1'b1, s[8]};
      if (c >= 4 && c <= 11) return {8'h00, 1'b1, s[(c >= 8) ? c - 8 : c]};
      return 10'h000;
   endfunction
   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #100000;
      err_count++;
      end_sim();
   end
   initial begin
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      go(1'b0, 8);
      chk("boot", mdl(word, 1'b0), 10'(acc));
      for (int i = 0; i < 6; i++) begin
         word = {7'h00, 4'($random(seed)), 4'ha, 1'b1};
         go(!pin_in, 10);
         chk("margin", mdl(word, pin_in), 10'(acc));
      end
      for (int c = 0; c < 16; c++) begin
         word = {11'h000, 4'(c), 1'b1};
         go(!pin_in, 10);
         if (c < 10 || c > 13) chk("other", 10'h000, 10'(acc));
      end
      word = 16'h0017;
      go(1'b1, 10);
      go(1'b0, 2);
      go(1'b1, 10);
      chk("short low", 10'h000, 10'(acc));
      go(1'b0, 8);
      go(1'b1, 10);
      chk("reset", 10'h001, 10'(acc));
      word = 16'h0019;
      go(1'b0, 8);
      chk("prog", 10'h001, 10'(allow));
      go(1'b1, 8);
      chk("prog", 10'h000, 10'(allow));
      word = 16'h001b;
      go(1'b0, 8);
      go(1'b1, 8);
      chk("write", 10'h000, 10'(wallow));
      unl = 1'b1;
      @(negedge clk);
      unl = 1'b0;
      ri2c = 1'b1;
      chk("exempt", 10'h001, 10'(exempt));
      go(1'b0, 8);
      ri2c = 1'b0;
      chk("write", 10'h001, 10'(wallow));
      for (int i = 0; i < 8; i++) begin
         word = (i < 4) ? 16'h01f5 : 16'h0000;
         sw = (i % 4 == 0) ? '0 : 10'($random(seed));
         @(negedge clk);
         if (i % 4 != 0) chk("sw", 10'(sw) & ((i < 4) ? 10'h003 : 10'h3ff),
            10'(sw_eff));
      end
      word = 16'h0019;
      sw = 10'($random(seed)) | 10'h001;
      @(negedge clk);
      chk("sw nvm", 10'(sw) & 10'h3fe, 10'(sw_eff));
      word = 16'h0017;
      sw = 10'($random(seed)) | 10'h002;
      @(negedge clk);
      chk("sw rst", 10'(sw) & 10'h3fd, 10'(sw_eff));
      sw = '0;
      for (int c = 0; c < 32; c++) begin
         word = {2'b00, 1'b1, 4'(c), 8'h00, c[4]};
         status = 9'($random(seed));
         repeat (2) @(negedge clk);
         chk("pin", omdl(word, status), {8'h00, pin_oe, pin_out});
      end
      end_sim();
   end
endmodule
bind gpio_function_mapper gpio_function_mapper_asserts
   u_gpio_function_mapper_asserts (.*);

// ### bench/pin_partner.sv
// partner: outside logic driving the pin level
// assumes: changes at the falling clock edge
`timescale 1ns/1ps
module pin_partner (
   input wire logic clk,
   output logic pin_in
);
   initial pin_in = 1'b0;
   task automatic drive(input logic v, input int hold);
      @(negedge clk);
      pin_in = v;
      repeat (hold) @(negedge clk);
   endtask
endmodule

// ### core/gpio_function_mapper.sv
// gpio function mapper: pin input triggers and pin output status select
// assumes: setup word held by the register file, which also honours
// the write-allow output; pin level is asynchronous to clk
`timescale 1ns/1ps
module gpio_function_mapper (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [15:0] pin_setup_word,
   input wire gpio_map_pkg::pin_status_s status,
   input wire gpio_map_pkg::sw_trig_s sw_trig,
   input wire logic wr_req_unlock,
   input wire logic wr_req_reset_i2c,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output gpio_map_pkg::pin_trig_s trig,
   output gpio_map_pkg::sw_trig_s sw_trig_eff,
   output logic nvm_prog_allow,
   output logic reg_write_allow,
   output logic reg_write_exempt
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ST_BOOT, ST_SETTLE, ST_FIRST, ST_RUN} phase_e;

   typedef struct packed {
      logic [gpio_map_pkg::SYNC_STAGES-1:0] sync;
      logic last;
      phase_e phase;
      logic [3:0] low_cnt;
      logic pin_out;
      logic pin_oe;
      gpio_map_pkg::pin_trig_s trig;
      gpio_map_pkg::sw_trig_s sw_eff;
      logic nvm_allow;
      logic wr_allow;
      logic wr_exempt;
   } state_s;

   state_s st_ff;
   state_s nxt_st;
   gpio_map_pkg::pin_setup_s cfg;
   logic lvl;
   logic rise;
   logic fall;
   logic first;
   logic sel_status;
   logic status_ok;

   assign cfg = gpio_map_pkg::unpack_setup(pin_setup_word);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // falling edge, or a low level taken once at boot
   function automatic logic go_low(input logic f, input logic b,
                                   input logic l);
      return f || (b && !l);
   endfunction

   // rising edge, or a high level taken once at boot
   function automatic logic go_high(input logic r, input logic b,
                                    input logic l);
      return r || (b && l);
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      // two-stage synchroniser; only stage two is read
      nxt_st.sync = {st_ff.sync[0], pin_in};
      lvl = st_ff.sync[gpio_map_pkg::SYNC_STAGES-1];
      nxt_st.last = lvl;
      first = (st_ff.phase == ST_FIRST);
      rise = lvl && !st_ff.last && (st_ff.phase == ST_RUN);
      fall = !lvl && st_ff.last && (st_ff.phase == ST_RUN);
      nxt_st.trig = '0;

      // settle the synchroniser, then take the level once
      case (st_ff.phase)
         // stage two holds the true pin level only from ST_FIRST on
         ST_BOOT: nxt_st.phase = ST_SETTLE;
         ST_SETTLE: nxt_st.phase = ST_FIRST;
         ST_FIRST: nxt_st.phase = ST_RUN;
         ST_RUN: nxt_st.phase = ST_RUN;
         default: nxt_st.phase = ST_BOOT;
      endcase

      if (cfg.in_en && !cfg.out_en) begin
         case (cfg.in_code)
            gpio_map_pkg::IN_MARGIN: begin
               if (go_low(fall, first, lvl))
                  nxt_st.trig.margin_low = cfg.ch_sel;
               if (go_high(rise, first, lvl))
                  nxt_st.trig.margin_high = cfg.ch_sel;
            end
            gpio_map_pkg::IN_RESET: begin
               // count synchronised low cycles; rising alone is inert
               if (lvl)
                  nxt_st.low_cnt = '0;
               else if (st_ff.low_cnt != gpio_map_pkg::RESET_LOW_CYCLES)
                  nxt_st.low_cnt = st_ff.low_cnt + 4'h1;
               if (lvl && st_ff.low_cnt == gpio_map_pkg::RESET_LOW_CYCLES)
                  nxt_st.trig.dev_reset = 1'b1;
            end
            gpio_map_pkg::IN_NVM_PROG: begin
               if (go_low(fall, first, lvl))
                  nxt_st.nvm_allow = 1'b1;
               else if (go_high(rise, first, lvl))
                  nxt_st.nvm_allow = 1'b0;
            end
            gpio_map_pkg::IN_WR_LOCK: begin
               if (go_low(fall, first, lvl))
                  nxt_st.wr_allow = 1'b1;
               else if (go_high(rise, first, lvl))
                  nxt_st.wr_allow = 1'b0;
            end
            default: nxt_st.low_cnt = '0;
         endcase
      end
      if (cfg.in_code != gpio_map_pkg::IN_RESET)
         nxt_st.low_cnt = '0;
      // leaving the lock code frees writes again
      if (!(cfg.in_en && cfg.in_code == gpio_map_pkg::IN_WR_LOCK))
         nxt_st.wr_allow = 1'b1;
      if (!(cfg.in_en && cfg.in_code == gpio_map_pkg::IN_NVM_PROG))
         nxt_st.nvm_allow = 1'b1;

      // refused writes still pass unlock, and reset fields over i2c
      nxt_st.wr_exempt = wr_req_unlock || wr_req_reset_i2c;

      // software triggers blocked while the pin owns the function
      nxt_st.sw_eff = sw_trig;
      if (cfg.in_en) begin
         case (cfg.in_code)
            gpio_map_pkg::IN_MARGIN: begin
               nxt_st.sw_eff.margin_low = '0;
               nxt_st.sw_eff.margin_high = '0;
            end
            gpio_map_pkg::IN_RESET: nxt_st.sw_eff.dev_reset = 1'b0;
            gpio_map_pkg::IN_NVM_PROG: nxt_st.sw_eff.nvm_prog = 1'b0;
            default: nxt_st.sw_eff = sw_trig;
         endcase
      end

      // output status select
      status_ok = 1'b1;
      sel_status = 1'b0;
      if (cfg.out_code == gpio_map_pkg::OUT_NONVOLATILE_BUSY_FLAG)
         sel_status = status.nonvolatile_busy_flag;
      else if (cfg.out_code >= gpio_map_pkg::OUT_CH_BUSY0 &&
               cfg.out_code <= gpio_map_pkg::OUT_CH_BUSY3)
         sel_status = status.ch_busy[cfg.out_code[1:0]];
      else if (cfg.out_code >= gpio_map_pkg::OUT_WIN0 &&
               cfg.out_code <= gpio_map_pkg::OUT_WIN3)
         sel_status = status.win_result[cfg.out_code[1:0]];
      else
         status_ok = 1'b0;
      nxt_st.pin_oe = cfg.out_en && !cfg.in_en && status_ok;
      nxt_st.pin_out = nxt_st.pin_oe && sel_status;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= '{sync: '0, last: 1'b0, phase: ST_BOOT, low_cnt: '0,
                    pin_out: 1'b0, pin_oe: 1'b0, trig: '0, sw_eff: '0,
                    nvm_allow: 1'b1, wr_allow: 1'b1, wr_exempt: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pin_out = st_ff.pin_out;
   assign pin_oe = st_ff.pin_oe;
   assign trig = st_ff.trig;
   assign sw_trig_eff = st_ff.sw_eff;
   assign nvm_prog_allow = st_ff.nvm_allow;
   assign reg_write_allow = st_ff.wr_allow;
   assign reg_write_exempt = st_ff.wr_exempt;

endmodule

// ### core/gpio_map_pkg.sv
// package: field layout, function codes and carriers of the pin mapper
// assumes: one 50 mhz clock, async active-low reset
package gpio_map_pkg;

   localparam int NUM_CH = 4;
   localparam int SYNC_STAGES = 2;

   // setup register field positions (16-bit pin setup word)
   localparam int PIN_IN_EN_BIT = 0;
   localparam int PIN_IN_CODE_LSB = 1;
   localparam int PIN_CH_SEL_LSB = 5;
   localparam int PIN_OUT_CODE_LSB = 9;
   localparam int PIN_OUT_EN_BIT = 13;
   localparam logic [15:0] PIN_SETUP_RESET = 16'h0000;

   // input function codes
   localparam logic [3:0] IN_MARGIN = 4'ha;
   localparam logic [3:0] IN_RESET = 4'hb;
   localparam logic [3:0] IN_NVM_PROG = 4'hc;
   localparam logic [3:0] IN_WR_LOCK = 4'hd;

   // output function codes
   localparam logic [3:0] OUT_NONVOLATILE_BUSY_FLAG = 4'h1;
   localparam logic [3:0] OUT_CH_BUSY0 = 4'h4;
   localparam logic [3:0] OUT_CH_BUSY3 = 4'h7;
   localparam logic [3:0] OUT_WIN0 = 4'h8;
   localparam logic [3:0] OUT_WIN3 = 4'hb;

   // low pulse must span this many synchronised cycles to reset
   localparam logic [3:0] RESET_LOW_CYCLES = 4'h4;

   typedef struct packed {
      logic in_en;
      logic out_en;
      logic [3:0] in_code;
      logic [3:0] out_code;
      logic [NUM_CH-1:0] ch_sel;
   } pin_setup_s;

   typedef struct packed {
      logic [NUM_CH-1:0] margin_low;
      logic [NUM_CH-1:0] margin_high;
      logic dev_reset;
   } pin_trig_s;

   typedef struct packed {
      logic nonvolatile_busy_flag;
      logic [NUM_CH-1:0] ch_busy;
      logic [NUM_CH-1:0] win_result;
   } pin_status_s;

   typedef struct packed {
      logic [NUM_CH-1:0] margin_low;
      logic [NUM_CH-1:0] margin_high;
      logic dev_reset;
      logic nvm_prog;
   } sw_trig_s;

   function automatic pin_setup_s unpack_setup(input logic [15:0] w);
      pin_setup_s s;
      s.in_en = w[PIN_IN_EN_BIT];
      s.out_en = w[PIN_OUT_EN_BIT];
      s.in_code = w[PIN_IN_CODE_LSB +: 4];
      s.out_code = w[PIN_OUT_CODE_LSB +: 4];
      s.ch_sel = w[PIN_CH_SEL_LSB +: NUM_CH];
      return s;
   endfunction

endpackage
